// file: hdl/host_port_pkg.sv
// host_port_pkg: widths, strap codes, register addresses and timing counts
// assumes a 100 MHz core clock shared by both ends of the parallel host port
package host_port_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 5;

  // interface-select strap codes
  localparam logic [2:0] SEL_CS_FRAMED = 3'h4;
  localparam logic [2:0] SEL_STROBE    = 3'h3;

  // register that holds the active interface type
  localparam logic [ADDR_W-1:0] IFACE_SEL_ADDR = 7'h7f;

  localparam int CLK_PERIOD_NS = 10;

  // device side limits, rounded down to whole cycles
  localparam int RD_RD_DATA_MAX_NS = 40;
  localparam int WR_RD_WAIT_MAX_NS = 182;
  localparam int RD_RD_DATA_MAX_CYC = RD_RD_DATA_MAX_NS / CLK_PERIOD_NS;
  localparam int WR_RD_WAIT_MAX_CYC = WR_RD_WAIT_MAX_NS / CLK_PERIOD_NS;

  // device internal latencies, kept inside the limits above
  localparam logic [CNT_W-1:0] RD_LAT_CYC  = 5'h02;
  localparam logic [CNT_W-1:0] WR_BUSY_CYC = 5'h0c;

  // host side least times, rounded up to whole cycles
  localparam int CS_LOW_MIN_NS = 25;
  localparam int WR_GAP_MIN_NS = 160;
  localparam int RD_GAP_MIN_NS = 15;
  localparam int CS_LOW_MIN_CYC = (CS_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_GAP_MIN_CYC = (WR_GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_GAP_MIN_CYC = (RD_GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// file: hdl/host_port_if.sv
// host_port_if: pins of the parallel host port between host and device
// assumes both ends run on the same clock; two-way pins resolved here
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
  import host_port_pkg::*;

  logic              chip_select_n;
  logic              write_strobe_n;
  logic              read_strobe_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_data;
  logic              host_data_oe;
  logic [DATA_W-1:0] dev_data;
  logic              dev_data_oe;
  logic              transfer_ack;
  logic              transfer_ack_oe;
  wire  [DATA_W-1:0] data_line;

  // a released bus settles at its pull-up level
  assign data_line = dev_data_oe ? dev_data : (host_data_oe ? host_data : {DATA_W{1'b1}});

  modport device (
    input  chip_select_n, write_strobe_n, read_strobe_n, addr, data_line,
    output dev_data, dev_data_oe, transfer_ack, transfer_ack_oe
  );

  modport host (
    input  data_line, transfer_ack, transfer_ack_oe,
    output chip_select_n, write_strobe_n, read_strobe_n, addr, host_data, host_data_oe
  );
endinterface
`default_nettype wire

// file: hdl/host_port_device.sv
// host_port_device: device end of the parallel host port with its register array
// assumes host pins are synchronous to clk_i and the host keeps its own timing
//
// Function
// RULE_01: cs-framed mode: address, data, chip select, direction
// RULE_02: host fixes direction before and during chip select
// RULE_03: cs-framed ack high while waiting, bounded
// RULE_04: host holds chip select until ack low
// RULE_05: cs-framed read data within bounded delay
// RULE_06: host holds chip select at least 25 ns
// RULE_07: host waits 160 ns after a write
// RULE_08: host waits 15 ns between reads
// RULE_09: strobe mode: separate read/write strobes, chip select
// RULE_10: host holds read strobe until ready high
// RULE_11: strobe mode ready low while waiting, bounded
// RULE_12: strobe mode read data within bounded delay
// RULE_13: host holds chip select past strobe release
// RULE_14: strobe mode: 160 ns after a write
// RULE_15: strobe mode: 15 ns after a read
// RULE_16: strap pins pick mode at reset
// RULE_17: software register changes interface type
// RULE_18: deselected: ignore strobes, release outputs
// RULE_19: wait ends only after register access done
`timescale 1ns/1ps
`default_nettype none
module host_port_device
  import host_port_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // strap pins
  input  wire logic [2:0]  host_port_select_i,
  // status
  output logic      [2:0]  active_mode_o,
  output logic             access_active_o,
  output logic             write_recovery_o,
  // host pins
  host_port_if.device      bus
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } dev_state_t;

  dev_state_t        state_reg;
  logic [2:0]        mode_reg;
  logic [CNT_W-1:0]  lat_cnt_reg;
  logic [CNT_W-1:0]  busy_cnt_reg;
  logic              wr_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] regs_mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] data_out_reg;
  logic              data_oe_reg;
  logic              ack_reg;
  logic              ack_oe_reg;
  logic              active_reg;
  logic              recov_reg;

  logic              mode_cs;
  logic              mode_sb;
  logic              cs_active;
  logic              start;
  logic              is_write;
  logic              commit;
  logic              sel_write;
  logic [DATA_W-1:0] rd_value;

  // mode decode and access start
  always_comb begin
    mode_cs   = (mode_reg == SEL_CS_FRAMED);
    mode_sb   = (mode_reg == SEL_STROBE);
    // deselected or disabled port sees nothing
    cs_active = !bus.chip_select_n && (mode_cs || mode_sb); // [RULE_18]
    is_write  = !bus.write_strobe_n;
    if (mode_cs) begin
      // direction line sampled at chip select fall
      start = (state_reg == ST_IDLE) && cs_active; // [RULE_01]
    end else begin
      start = (state_reg == ST_IDLE) && cs_active &&
              (!bus.read_strobe_n || !bus.write_strobe_n); // [RULE_09]
    end
  end

  // an access finishes only once the register array is free
  always_comb begin
    commit    = (state_reg == ST_WAIT) && cs_active &&
                (lat_cnt_reg == '0) && (busy_cnt_reg == '0); // [RULE_19]
    sel_write = commit && wr_reg && (addr_reg == IFACE_SEL_ADDR);
    if (addr_reg == IFACE_SEL_ADDR) begin
      rd_value = {{(DATA_W-3){1'b0}}, mode_reg};
    end else begin
      rd_value = regs_mem[addr_reg];
    end
  end

  // access sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg   <= ST_IDLE;
      lat_cnt_reg <= '0;
      wr_reg      <= 1'b0;
      addr_reg    <= '0;
    end else if (ce_i) begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg   <= ST_WAIT;
            lat_cnt_reg <= RD_LAT_CYC;
            wr_reg      <= is_write;
            addr_reg    <= bus.addr;
          end
        end
        ST_WAIT: begin
          if (!cs_active) begin
            state_reg <= ST_IDLE; // [RULE_18]
          end else if (commit) begin
            state_reg <= ST_DONE;
          end else if (lat_cnt_reg != '0) begin
            lat_cnt_reg <= lat_cnt_reg - 5'h01;
          end
        end
        ST_DONE: begin
          if (!cs_active) begin
            state_reg <= ST_IDLE;
          end else if (mode_sb && bus.read_strobe_n && bus.write_strobe_n) begin
            // strobe released while chip select stays low
            state_reg <= ST_IDLE; // [RULE_09]
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // interface type: strap caught at reset, later set by software
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_reg <= host_port_select_i; // [RULE_16]
    end else if (ce_i && sel_write) begin
      mode_reg <= bus.data_line[2:0]; // [RULE_17]
    end
  end

  // register array, written at the end of a write access
  always_ff @(posedge clk_i) begin
    if (ce_i && commit && wr_reg && (addr_reg != IFACE_SEL_ADDR)) begin
      regs_mem[addr_reg] <= bus.data_line; // [RULE_19]
    end
  end

  // internal write takes time; a following access waits for it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_cnt_reg <= '0;
      recov_reg    <= 1'b0;
    end else if (ce_i) begin
      if (commit && wr_reg) begin
        busy_cnt_reg <= WR_BUSY_CYC; // [RULE_03] [RULE_11]
        recov_reg    <= 1'b1;
      end else if (busy_cnt_reg != '0) begin
        busy_cnt_reg <= busy_cnt_reg - 5'h01;
        // status flop follows the counter's next value
        recov_reg    <= (busy_cnt_reg != 5'h01);
      end
    end
  end

  // ack/ready and data pins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_reg      <= 1'b0;
      ack_oe_reg   <= 1'b0;
      data_oe_reg  <= 1'b0;
      data_out_reg <= '0;
    end else if (ce_i) begin
      if (!cs_active) begin
        ack_oe_reg  <= 1'b0; // [RULE_18]
        data_oe_reg <= 1'b0; // [RULE_18]
      end else begin
        ack_oe_reg <= 1'b1;
        case (state_reg)
          ST_IDLE: begin
            // cs-framed: high means wait; strobe mode: low means wait
            ack_reg <= mode_cs || !start; // [RULE_03] [RULE_11]
          end
          ST_WAIT: begin
            if (commit) begin
              ack_reg      <= mode_sb; // [RULE_03] [RULE_11]
              data_oe_reg  <= !wr_reg; // [RULE_05] [RULE_12]
              data_out_reg <= rd_value;
            end else begin
              ack_reg <= mode_cs;
            end
          end
          ST_DONE: begin
            if (mode_sb && bus.read_strobe_n) begin
              data_oe_reg <= 1'b0;
            end
          end
          default: begin
            ack_reg <= mode_cs;
          end
        endcase
      end
    end
  end

  // status outputs
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      active_reg <= 1'b0;
    end else if (ce_i) begin
      active_reg <= (state_reg != ST_IDLE);
    end
  end

  assign bus.transfer_ack    = ack_reg;
  assign bus.transfer_ack_oe = ack_oe_reg;
  assign bus.dev_data        = data_out_reg;
  assign bus.dev_data_oe     = data_oe_reg;
  assign active_mode_o       = mode_reg;
  assign access_active_o     = active_reg;
  assign write_recovery_o    = recov_reg;

endmodule
`default_nettype wire

// file: hdl/host_port_host.sv
// host_port_host: host end, runs one register access per request
// assumes device pins are synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module host_port_host
  import host_port_pkg::*;
(
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  // 1: separate strobes, 0: chip-select framed
  input  wire logic              strobe_mode_i,
  // request
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  output logic                   req_ready_o,
  // answer
  output logic                   done_o,
  output logic      [DATA_W-1:0] rdata_o,
  // device pins
  host_port_if.host              bus
);

  typedef enum logic [2:0] {
    HS_IDLE    = 3'b000,
    HS_SETUP   = 3'b001,
    HS_ACTIVE  = 3'b011,
    HS_RELEASE = 3'b010,
    HS_GAP     = 3'b110
  } host_state_t;

  host_state_t       state_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              wr_reg;
  logic              sb_reg;
  logic              saw_low_reg;
  logic              cs_n_reg;
  logic              wr_n_reg;
  logic              rd_n_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic              data_oe_reg;
  logic              ready_reg;
  logic              done_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              complete;

  // access over: ack low (framed) or ready back high after a low (strobes)
  always_comb begin
    if (sb_reg) begin
      complete = (cnt_reg == '0) && saw_low_reg &&
                 bus.transfer_ack_oe && bus.transfer_ack; // [RULE_10]
    end else begin
      complete = (cnt_reg == '0) && bus.transfer_ack_oe && !bus.transfer_ack; // [RULE_04] [RULE_06]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg   <= HS_IDLE;
      cnt_reg     <= '0;
      wr_reg      <= 1'b0;
      sb_reg      <= 1'b0;
      saw_low_reg <= 1'b0;
      cs_n_reg    <= 1'b1;
      wr_n_reg    <= 1'b1;
      rd_n_reg    <= 1'b1;
      addr_reg    <= '0;
      wdata_reg   <= '0;
      data_oe_reg <= 1'b0;
      ready_reg   <= 1'b0;
      done_reg    <= 1'b0;
      rdata_reg   <= '0;
    end else if (ce_i) begin
      done_reg <= 1'b0;
      case (state_reg)
        HS_IDLE: begin
          ready_reg <= 1'b1;
          if (req_valid_i && ready_reg) begin
            ready_reg   <= 1'b0;
            wr_reg      <= req_write_i;
            sb_reg      <= strobe_mode_i;
            addr_reg    <= req_addr_i;
            wdata_reg   <= req_wdata_i;
            data_oe_reg <= req_write_i;
            // framed mode: direction set before chip select falls
            wr_n_reg    <= strobe_mode_i || !req_write_i; // [RULE_02]
            state_reg   <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          cs_n_reg    <= 1'b0;
          saw_low_reg <= 1'b0;
          cnt_reg     <= 5'(CS_LOW_MIN_CYC - 1); // [RULE_06]
          if (sb_reg) begin
            rd_n_reg <= wr_reg;
            wr_n_reg <= !wr_reg;
          end
          state_reg <= HS_ACTIVE;
        end
        HS_ACTIVE: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 5'h01;
          end
          if (bus.transfer_ack_oe && !bus.transfer_ack) begin
            saw_low_reg <= 1'b1;
          end
          if (complete) begin
            rdata_reg <= bus.data_line;
            done_reg  <= 1'b1;
            if (sb_reg) begin
              rd_n_reg <= 1'b1;
              wr_n_reg <= 1'b1;
            end
            state_reg <= HS_RELEASE;
          end
        end
        HS_RELEASE: begin
          // chip select rises after the strobe
          cs_n_reg    <= 1'b1; // [RULE_13]
          wr_n_reg    <= 1'b1;
          data_oe_reg <= 1'b0;
          if (wr_reg) begin
            cnt_reg <= 5'(WR_GAP_MIN_CYC - 1); // [RULE_07] [RULE_14]
          end else begin
            cnt_reg <= 5'(RD_GAP_MIN_CYC - 1); // [RULE_08] [RULE_15]
          end
          state_reg <= HS_GAP;
        end
        HS_GAP: begin
          if (cnt_reg == '0) begin
            state_reg <= HS_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 5'h01;
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end

  assign bus.chip_select_n  = cs_n_reg;
  assign bus.write_strobe_n = wr_n_reg;
  assign bus.read_strobe_n  = rd_n_reg;
  assign bus.addr           = addr_reg;
  assign bus.host_data      = wdata_reg;
  assign bus.host_data_oe   = data_oe_reg;
  assign req_ready_o        = ready_reg;
  assign done_o             = done_reg;
  assign rdata_o            = rdata_reg;

endmodule
`default_nettype wire

// file: bench/host_port_sva.sv
// host_port_sva: timing checks on the device side of the parallel host port
// assumes one clock for both ends; instantiated beside the interface it watches
`timescale 1ns/1ps
`default_nettype none
module host_port_sva
  import host_port_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // device status
  input  wire logic [2:0]        active_mode_o,
  // host pins
  input  wire logic              chip_select_n,
  input  wire logic              write_strobe_n,
  input  wire logic              read_strobe_n,
  // device pins
  input  wire logic [DATA_W-1:0] dev_data,
  input  wire logic              dev_data_oe,
  input  wire logic              transfer_ack,
  input  wire logic              transfer_ack_oe
);
  logic cs_q;
  logic wr_q;
  logic rd_q;
  logic wr_cur;
  wire  framed   = (active_mode_o == SEL_CS_FRAMED);
  wire  strobe   = (active_mode_o == SEL_STROBE);
  wire  rd_fall  = rd_q && !read_strobe_n;
  wire  wr_fall  = wr_q && !write_strobe_n;
  // edge at which the device takes an access
  wire  start    = !chip_select_n && ((framed && cs_q) || (strobe && (rd_fall || wr_fall)));
  wire  rd_start = start && write_strobe_n;
  wire  done     = transfer_ack_oe && (transfer_ack == strobe) && dev_data_oe;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cs_q <= 1'b1;
      wr_q <= 1'b1;
      rd_q <= 1'b1;
    end else begin
      cs_q <= chip_select_n;
      wr_q <= write_strobe_n;
      rd_q <= read_strobe_n;
    end
  end

  // direction of the last access taken
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_cur <= 1'b0;
    end else if (start) begin
      wr_cur <= !write_strobe_n;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_idle_quiet: assert property (chip_select_n && cs_q |-> !dev_data_oe && !transfer_ack_oe)
    else $error("outputs driven while deselected");
  a_data_on_read: assert property (dev_data_oe |-> write_strobe_n)
    else $error("data driven during a write");
  a_framed_wait_high: assert property (framed && start |=> transfer_ack_oe && transfer_ack)
    else $error("framed wait not signalled high");
  a_strobe_wait_low: assert property (strobe && start |=> transfer_ack_oe && !transfer_ack)
    else $error("strobe wait not signalled low");
  a_framed_rr_read: assert property (framed && rd_start && !wr_cur |-> ##[1:4] done)
    else $error("framed read after read too slow");
  a_strobe_rr_read: assert property (strobe && rd_start && !wr_cur |-> ##[1:4] done)
    else $error("strobe read after read too slow");
  a_wr_rd_read: assert property (rd_start && wr_cur |-> ##[1:18] done)
    else $error("read after write too slow");
  a_framed_data_stands: assert property (framed && dev_data_oe && !chip_select_n
    |=> dev_data_oe && $stable(dev_data))
    else $error("framed read data not held");
  a_strobe_data_stands: assert property (strobe && dev_data_oe && !read_strobe_n
    |=> dev_data_oe && $stable(dev_data))
    else $error("strobe read data not held");
endmodule
`default_nettype wire

// file: bench/test_parallel_host_bus_port.sv
// test_parallel_host_bus_port: host and device joined, plus a lone device on a rule-breaking driver
// assumes a 100 MHz clock and inputs driven at the falling edge
`timescale 1ns/1ps
`default_nettype none
module test_parallel_host_bus_port;
  import host_port_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              ce_i = 1'b1;
  logic [2:0]        strap = SEL_CS_FRAMED;
  logic              strobe_mode = 1'b0;
  logic              req_valid = 1'b0;
  logic              req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic              req_ready;
  logic              done;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rd_byte;
  logic [2:0]        active_mode;
  logic              write_recovery;
  logic              last_recov;
  logic              active2;
  logic              recov2;
  int                err_count = 0;
  int                n_tests = 0;
  int                cycles = 0;

  host_port_if bus_if();
  host_port_if bus2_if();

  always #5 clk_i = ~clk_i;

  host_port_device host_port_device_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .host_port_select_i(strap), .active_mode_o(active_mode), .access_active_o(),
    .write_recovery_o(write_recovery), .bus(bus_if));
  host_port_host host_port_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .strobe_mode_i(strobe_mode), .req_valid_i(req_valid), .req_write_i(req_write),
    .req_addr_i(req_addr), .req_wdata_i(req_wdata), .req_ready_o(req_ready),
    .done_o(done), .rdata_o(rdata), .bus(bus_if));
  host_port_device host_port_device_inst_b (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .host_port_select_i(SEL_CS_FRAMED), .active_mode_o(), .access_active_o(active2),
    .write_recovery_o(recov2), .bus(bus2_if));
  host_port_sva host_port_sva_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .active_mode_o(active_mode),
    .chip_select_n(bus_if.chip_select_n), .write_strobe_n(bus_if.write_strobe_n),
    .read_strobe_n(bus_if.read_strobe_n), .dev_data(bus_if.dev_data), .dev_data_oe(bus_if.dev_data_oe),
    .transfer_ack(bus_if.transfer_ack), .transfer_ack_oe(bus_if.transfer_ack_oe));

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // one access through the host end; read data lands in rd_byte
  task automatic host_access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge clk_i);
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk_val({7'h0, done}, 8'h01);
    rd_byte = rdata;
    last_recov = write_recovery;
  endtask

  task automatic t_framed_rw;
    logic [ADDR_W-1:0] adr[3];
    logic [DATA_W-1:0] dat[3];
    adr = '{7'h00, 7'h3c, 7'h7e};
    dat = '{8'h00, 8'hff, 8'h5a};
    chk_val({5'h0, active_mode}, {5'h0, SEL_CS_FRAMED});
    for (int i = 0; i < 3; i++) begin
      host_access(1'b1, adr[i], dat[i]);
      chk_val({7'h0, last_recov}, 8'h01);
    end
    for (int i = 0; i < 3; i++) begin
      host_access(1'b0, adr[i], 8'h00);
      chk_val(rd_byte, dat[i]);
    end
  endtask

  task automatic t_mode_switch;
    host_access(1'b1, IFACE_SEL_ADDR, {5'h0, SEL_STROBE});
    chk_val({5'h0, active_mode}, {5'h0, SEL_STROBE});
    strobe_mode = 1'b1;
    host_access(1'b1, 7'h21, 8'hc3);
    host_access(1'b0, 7'h21, 8'h00);
    chk_val(rd_byte, 8'hc3);
    host_access(1'b0, 7'h3c, 8'h00);
    chk_val(rd_byte, 8'hff);
    host_access(1'b1, IFACE_SEL_ADDR, {5'h0, SEL_CS_FRAMED});
    chk_val({5'h0, active_mode}, {5'h0, SEL_CS_FRAMED});
    strobe_mode = 1'b0;
  endtask

  task automatic t_strap_reset;
    strap = SEL_STROBE;
    strobe_mode = 1'b1;
    rst_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk_val({5'h0, active_mode}, {5'h0, SEL_STROBE});
    host_access(1'b1, 7'h44, 8'h96);
    host_access(1'b0, 7'h44, 8'h00);
    chk_val(rd_byte, 8'h96);
  endtask

  // clock enable low holds both ends where they stand
  task automatic t_freeze;
    ce_i = 1'b0;
    req_valid = 1'b1;
    req_write = 1'b0;
    req_addr = 7'h44;
    repeat (8) @(negedge clk_i);
    chk_val({5'h0, req_ready, bus_if.chip_select_n, bus_if.read_strobe_n}, 8'h01);
    req_valid = 1'b0;
    ce_i = 1'b1;
    host_access(1'b0, 7'h44, 8'h00);
    chk_val(rd_byte, 8'h96);
  endtask

  // strobes without chip select, then a write cut short
  task automatic t_deselect;
    bus2_if.write_strobe_n = 1'b0;
    bus2_if.read_strobe_n = 1'b0;
    repeat (4) @(negedge clk_i);
    chk_val({6'h0, bus2_if.dev_data_oe, bus2_if.transfer_ack_oe}, 8'h00);
    chk_val({7'h0, active2}, 8'h00);
    bus2_if.read_strobe_n = 1'b1;
    bus2_if.chip_select_n = 1'b0;
    @(negedge clk_i);
    bus2_if.chip_select_n = 1'b1;
    repeat (6) @(negedge clk_i);
    chk_val({7'h0, recov2}, 8'h00);
    chk_val({7'h0, active2}, 8'h00);
    chk_val({6'h0, bus2_if.dev_data_oe, bus2_if.transfer_ack_oe}, 8'h00);
  endtask

  initial begin
    bus2_if.chip_select_n = 1'b1;
    bus2_if.write_strobe_n = 1'b1;
    bus2_if.read_strobe_n = 1'b1;
    bus2_if.addr = 7'h05;
    bus2_if.host_data = 8'h3e;
    bus2_if.host_data_oe = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_framed_rw();
    t_mode_switch();
    t_strap_reset();
    t_freeze();
    t_deselect();
    complete_run();
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      complete_run();
    end
  end
endmodule
`default_nettype wire
